// ---- core/rpbc_pkg.sv ----
// Package: register map, fields, reset values and timing for the reset/boot block
package rpbc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_SYSCFG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_BUSCFG = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  // System config fields
  localparam int BIT_BIDIR_EN = 0;
  // Command fields (write one to trigger)
  localparam int BIT_CMD_SWRST = 0;
  localparam int BIT_CMD_END_OF_INIT_INSTR = 1;
  // Status fields
  localparam int BIT_ST_LONG_HW = 0;
  localparam int BIT_ST_SW = 1;
  localparam int BIT_ST_WDT = 2;
  localparam int BIT_ST_SINGLE = 3;
  localparam int BIT_ST_BOOT = 4;
  localparam int BIT_ST_INIT_DONE = 5;
  localparam int BIT_ST_RESET_OUT_LINE = 6;
  // Default bus config fields
  localparam int BIT_BUS_ACTIVE = 10;
  localparam logic [15:0] BUSCFG_SINGLE_RESET = 16'h00C0;
  localparam logic [15:0] BUSCFG_EXT_RESET = 16'h0680;
  // Interrupt event bits
  localparam int IRQ_RESET_DONE = 0;
  localparam int IRQ_ILL_BUS = 1;
  localparam int IRQ_WIDTH = 2;
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int RESET_SEQ_NS = 5120;
  localparam int RESET_SEQ_CYC = (RESET_SEQ_NS * CLK_MHZ) / 1000;
  localparam int SEQ_CNT_W = 11;
  localparam logic [SEQ_CNT_W-1:0] SEQ_LAST = SEQ_CNT_W'(RESET_SEQ_CYC - 1);
  // Reset sequencer states
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_SEQ = 2'b10
  } rpbc_state_e;
endpackage : rpbc_pkg

// ---- core/rpbc_reset_boot.sv ----
// Reset pin control, reset sequencing, start configuration capture
//
// What this block does
// - Bidir enable makes reset input open-drain
// - Internal resets drive reset line low in bidir mode
// - Bidir enable locked after init, reset-cleared
// - Bidir mode flags report long hardware reset
// - Bidir mode evaluates boot loader strap
// - Short external pulses stretched to sequence
// - Reset output asserted on every sequence
// - Reset output released only by init-end
// - Access strap high: single-chip, bus 00C0
// - Single-chip: no bus, software may enable
// - Unenabled external access raises bus trap
// - Straps captured at sequence end
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module rpbc_reset_boot
  import rpbc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic reset_in_line_i,
  output logic reset_in_line_o,
  output logic reset_in_line_oe,
  output logic reset_out_line_n,
  input wire logic watchdog_overflow,
  input wire logic external_access_strap,
  input wire logic boot_loader_strap_bit,
  input wire logic ext_mem_access,
  output logic illegal_bus_trap,
  output logic boot_loader_enable,
  output logic single_chip_mode,
  output logic core_reset_n,
  output logic irq
);
  // Pin synchronisers
  logic rin_m, rin_s, ea_m, ea_s, bl_m, bl_s;
  logic next_rin_m, next_rin_s, next_ea_m, next_ea_s, next_bl_m, next_bl_s;
  // Sequencer and register state
  rpbc_state_e state, next_state;
  logic [SEQ_CNT_W-1:0] cnt, next_cnt;
  logic bidir_reset_enable, next_bidir;
  logic init_done, next_init_done;
  logic rout_n, next_rout_n;
  logic [15:0] default_bus_config_reg, next_buscfg;
  logic single, next_single, boot, next_boot;
  logic flag_long, flag_sw, flag_wdt, next_flag_long, next_flag_sw, next_flag_wdt;
  logic [IRQ_WIDTH-1:0] irq_stat, irq_mask, next_irq_stat, next_irq_mask;
  logic trap, next_trap;
  logic drive_line, next_drive_line;
  // Bus address phase capture
  logic dp_wr, next_dp_wr;
  logic [7:0] dp_addr, next_dp_addr;
  logic [31:0] rdata, next_rdata;

  logic addr_phase, rd_now, wr_sysc, wr_cmd, wr_bus, wr_isc, wr_imk;
  logic sw_rst, end_of_init_instr_cmd, ext_low, trig, seq_end;

  assign addr_phase = hsel && hready && htrans[1];
  assign wr_sysc = dp_wr && (dp_addr == ADDR_SYSCFG);
  assign wr_cmd = dp_wr && (dp_addr == ADDR_CMD);
  assign wr_bus = dp_wr && (dp_addr == ADDR_BUSCFG);
  assign wr_isc = dp_wr && (dp_addr == ADDR_IRQ_STAT);
  assign wr_imk = dp_wr && (dp_addr == ADDR_IRQ_MASK);
  assign rd_now = addr_phase && !hwrite;
  assign sw_rst = wr_cmd && hwdata[BIT_CMD_SWRST];
  assign end_of_init_instr_cmd = wr_cmd && hwdata[BIT_CMD_END_OF_INIT_INSTR];
  // Our own drive is excluded; the line shows low from outside only
  assign ext_low = !rin_s && !reset_in_line_oe;
  assign trig = sw_rst || watchdog_overflow || ext_low;
  assign seq_end = (state == ST_SEQ) && (cnt == SEQ_LAST);

  always_comb begin
    next_rin_m = reset_in_line_i;
    next_rin_s = rin_m;
    next_ea_m = external_access_strap;
    next_ea_s = ea_m;
    next_bl_m = boot_loader_strap_bit;
    next_bl_s = bl_m;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rin_m <= 1'b1;
      rin_s <= 1'b1;
      ea_m <= 1'b0;
      ea_s <= 1'b0;
      bl_m <= 1'b1;
      bl_s <= 1'b1;
    end else begin
      rin_m <= next_rin_m;
      rin_s <= next_rin_s;
      ea_m <= next_ea_m;
      ea_s <= next_ea_s;
      bl_m <= next_bl_m;
      bl_s <= next_bl_s;
    end
  end

  // Reset sequencer and configuration
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bidir = bidir_reset_enable;
    next_init_done = init_done;
    next_rout_n = rout_n;
    next_buscfg = default_bus_config_reg;
    next_single = single;
    next_boot = boot;
    next_flag_long = flag_long;
    next_flag_sw = flag_sw;
    next_flag_wdt = flag_wdt;
    next_drive_line = drive_line;
    case (state)
      ST_RUN: begin
        if (trig) begin
          next_state = ST_SEQ;
          next_cnt = '0;
          next_rout_n = 1'b0;
          // drive line if bidir was on
          next_drive_line = bidir_reset_enable;
          next_bidir = 1'b0;
          next_init_done = 1'b0;
          // long hardware flag in bidir mode
          next_flag_long = ext_low || bidir_reset_enable;
          next_flag_sw = sw_rst && !bidir_reset_enable;
          next_flag_wdt = watchdog_overflow && !sw_rst && !bidir_reset_enable;
        end else begin
          if (wr_sysc && !init_done) begin
            next_bidir = hwdata[BIT_BIDIR_EN];
          end
          if (wr_bus) begin
            next_buscfg = hwdata[15:0];
          end
          if (end_of_init_instr_cmd) begin
            next_init_done = 1'b1;
            next_rout_n = 1'b1;
          end
        end
      end
      ST_SEQ: begin
        if (!seq_end) begin
          next_cnt = cnt + 1'b1;
        end else if (rin_s) begin
          next_state = ST_RUN;
          next_single = ea_s;
          // strap read on hardware or bidir reset
          if (flag_long) begin
            next_boot = ea_s && !bl_s;
          end
          next_buscfg = ea_s ? BUSCFG_SINGLE_RESET : BUSCFG_EXT_RESET;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_SEQ;
      cnt <= '0;
      bidir_reset_enable <= 1'b0;
      init_done <= 1'b0;
      rout_n <= 1'b0;
      default_bus_config_reg <= BUSCFG_EXT_RESET;
      single <= 1'b0;
      boot <= 1'b0;
      flag_long <= 1'b1;
      flag_sw <= 1'b0;
      flag_wdt <= 1'b0;
      drive_line <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bidir_reset_enable <= next_bidir;
      init_done <= next_init_done;
      rout_n <= next_rout_n;
      default_bus_config_reg <= next_buscfg;
      single <= next_single;
      boot <= next_boot;
      flag_long <= next_flag_long;
      flag_sw <= next_flag_sw;
      flag_wdt <= next_flag_wdt;
      drive_line <= next_drive_line;
    end
  end

  // Trap, interrupts and bus slave
  always_comb begin
    next_trap = 1'b0;
    if (single && !default_bus_config_reg[BIT_BUS_ACTIVE] && ext_mem_access) begin
      next_trap = 1'b1;
    end
    next_irq_stat = irq_stat;
    if (wr_isc) begin
      next_irq_stat = irq_stat & ~hwdata[IRQ_WIDTH-1:0];
    end
    // Set wins over clear
    if (seq_end && rin_s) begin
      next_irq_stat[IRQ_RESET_DONE] = 1'b1;
    end
    if (next_trap) begin
      next_irq_stat[IRQ_ILL_BUS] = 1'b1;
    end
    next_irq_mask = wr_imk ? hwdata[IRQ_WIDTH-1:0] : irq_mask;
    next_dp_wr = addr_phase && hwrite;
    next_dp_addr = addr_phase ? haddr[7:0] : dp_addr;
    next_rdata = rdata;
    if (rd_now) begin
      case (haddr[7:0])
        ADDR_SYSCFG: next_rdata = {31'h0, bidir_reset_enable};
        ADDR_STATUS: next_rdata = {25'h0, !rout_n, init_done, boot, single,
                                   flag_wdt, flag_sw, flag_long};
        ADDR_BUSCFG: next_rdata = {16'h0, default_bus_config_reg};
        ADDR_IRQ_STAT: next_rdata = {30'h0, irq_stat};
        ADDR_IRQ_MASK: next_rdata = {30'h0, irq_mask};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trap <= 1'b0;
      irq_stat <= '0;
      irq_mask <= '0;
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
      rdata <= 32'h0;
    end else begin
      trap <= next_trap;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      dp_wr <= next_dp_wr;
      dp_addr <= next_dp_addr;
      rdata <= next_rdata;
    end
  end

  assign hrdata = rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // open-drain line, driven low during a sequence started in bidir mode
  assign reset_in_line_o = 1'b0;
  // Drive dropped at last count so outside drivers become visible
  assign reset_in_line_oe = drive_line && (state == ST_SEQ) && (cnt != SEQ_LAST);
  // emulation drive is external; pin stays a plain output here
  assign reset_out_line_n = rout_n;
  assign illegal_bus_trap = trap;
  assign boot_loader_enable = boot;
  assign single_chip_mode = single;
  assign core_reset_n = (state == ST_RUN);
  assign irq = |(irq_stat & irq_mask);

  AST_ROUT_ASSERT: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_RUN && trig) |=> !reset_out_line_n)
    else $error("reset output not asserted at sequence start");
  // output stays low until init end
  AST_ROUT_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (!reset_out_line_n && !end_of_init_instr_cmd) |=> !reset_out_line_n)
    else $error("reset output released without init end");
  AST_BIDIR_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
    (init_done && state == ST_RUN && !trig) |=> $stable(bidir_reset_enable))
    else $error("bidir enable changed after init");
  // line driven at sequence start with bidir
  AST_LINE_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_RUN && trig && bidir_reset_enable) |=> reset_in_line_oe)
    else $error("reset line not driven low");
  AST_LONG_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_RUN && trig && bidir_reset_enable) |=> flag_long && !flag_sw)
    else $error("flags do not show long hardware reset");
  AST_SEQ_LEN: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_RUN && trig) |=> (state == ST_SEQ) [*8])
    else $error("sequence shorter than expected");
  AST_SINGLE_BUS: assert property (@(posedge hclk) disable iff (!hresetn)
    (seq_end && rin_s && ea_s) |=> default_bus_config_reg == BUSCFG_SINGLE_RESET)
    else $error("single-chip bus default not loaded");
  AST_TRAP: assert property (@(posedge hclk) disable iff (!hresetn)
    (single && !default_bus_config_reg[BIT_BUS_ACTIVE] && ext_mem_access)
    |=> illegal_bus_trap)
    else $error("illegal bus trap missing");
  AST_NO_EARLY_END: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_SEQ && cnt != SEQ_LAST) |=> (state == ST_SEQ))
    else $error("reset sequence ended early");
  AST_LINE_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_RUN) |-> !reset_in_line_oe)
    else $error("reset line driven outside sequence");
  // boot strap taken on long reset
  AST_BOOT: assert property (@(posedge hclk) disable iff (!hresetn)
    (seq_end && rin_s && flag_long && ea_s && !bl_s) |=> boot_loader_enable)
    else $error("boot loader not enabled by strap");
  AST_STRAP_SINGLE: assert property (@(posedge hclk) disable iff (!hresetn)
    (seq_end && rin_s) |=> single_chip_mode == $past(ea_s))
    else $error("single chip mode not latched from strap");
  AST_END_OF_INIT_INSTR_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_RUN && !trig && end_of_init_instr_cmd) |=> reset_out_line_n)
    else $error("reset output not released at init end");
  AST_TRAP_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
    !(single && !default_bus_config_reg[BIT_BUS_ACTIVE] && ext_mem_access) |=> !illegal_bus_trap)
    else $error("illegal bus trap without cause");
  COV_SWRST: cover property (@(posedge hclk) disable iff (!hresetn)
    state == ST_RUN && sw_rst);
  COV_BIDIR: cover property (@(posedge hclk) disable iff (!hresetn) reset_in_line_oe);
  COV_END_OF_INIT_INSTR: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(reset_out_line_n));
  COV_WDOG: cover property (@(posedge hclk) disable iff (!hresetn)
    state == ST_RUN && watchdog_overflow);
  COV_STRETCH: cover property (@(posedge hclk) disable iff (!hresetn)
    state == ST_RUN && ext_low);
endmodule : rpbc_reset_boot

// ---- verification/reset_pin_and_boot_mode_ctrl_bench.sv ----
// Self-checking bench for the reset pin and start configuration block
`timescale 1ns/1ps
module reset_pin_and_boot_mode_ctrl_bench;
  import rpbc_pkg::*;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd, mask, d;
  logic hreadyout, hresp, rin_o, rin_oe, rin, rout_n;
  logic trap, boot_en, single, core_rst_n, irq;
  logic wdog = 1'h0;
  logic strap = 1'h1;
  logic boot_bit = 1'h0;
  logic ext_acc = 1'h0;
  logic go = 1'h0;
  int error_cnt = 0;
  int compares = 0;
  int n;
  int seed = 48709;
  always #2.5 hclk = ~hclk;
  rpbc_reset_boot dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .reset_in_line_i(rin),
    .reset_in_line_o(rin_o), .reset_in_line_oe(rin_oe), .reset_out_line_n(rout_n),
    .watchdog_overflow(wdog), .external_access_strap(strap), .boot_loader_strap_bit(boot_bit),
    .ext_mem_access(ext_acc), .illegal_bus_trap(trap), .boot_loader_enable(boot_en),
    .single_chip_mode(single), .core_reset_n(core_rst_n), .irq(irq));
  rpbc_ext_reset ext (.hclk(hclk), .go(go), .len(8'h03), .dut_o(rin_o), .dut_oe(rin_oe),
    .line(rin));
  function automatic logic exp_irq(input logic [1:0] st, input logic [1:0] mk);
    return |(st & mk);
  endfunction : exp_irq
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
    chk(hresp, 32'h0);
  endtask : xfer
  task access(input logic exp);
    @(posedge hclk);
    ext_acc <= 1'h1;
    @(posedge hclk);
    ext_acc <= 1'h0;
    @(posedge hclk);
    chk(trap, exp);
  endtask : access
  task measure(input logic exp_oe);
    n = 0;
    while (core_rst_n !== 1'h0 && n < 8) begin
      @(posedge hclk);
      n++;
    end
    chk(rin_oe, exp_oe);
    chk(rout_n, 32'h0);
    n = 0;
    while (core_rst_n !== 1'h1 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    chk(n >= 1022 && n <= 1032, 32'h1);
    chk(rin_oe, 32'h0);
    chk(rout_n, 32'h0);
  endtask : measure
  task tally_and_finish;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #150000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    measure(1'h0);
    chk(single, 32'h1);
    chk(boot_en, 32'h1);
    xfer(1'h0, ADDR_BUSCFG, 32'h0);
    chk(rd, 32'h000000C0);
    access(1'h1);
    xfer(1'h0, ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h3);
    chk(irq, 32'h0);
    for (int i = 0; i < 4; i++) begin
      mask = $random(seed) & 32'h3;
      d = $random(seed) & 32'hFFFF;
      xfer(1'h1, ADDR_IRQ_MASK, mask);
      @(posedge hclk);
      chk(irq, exp_irq(2'h3, mask[1:0]));
      xfer(1'h1, ADDR_BUSCFG, d);
      xfer(1'h0, ADDR_BUSCFG, 32'h0);
      chk(rd, d);
    end
    xfer(1'h1, ADDR_IRQ_STAT, 32'h2);
    xfer(1'h0, ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h1);
    chk(irq, exp_irq(2'h1, mask[1:0]));
    xfer(1'h1, ADDR_BUSCFG, 32'h400);
    access(1'h0);
    xfer(1'h0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    xfer(1'h1, ADDR_SYSCFG, 32'h1);
    xfer(1'h0, ADDR_SYSCFG, 32'h0);
    chk(rd, 32'h1);
    xfer(1'h1, ADDR_CMD, 32'h1);
    measure(1'h1);
    xfer(1'h0, ADDR_SYSCFG, 32'h0);
    chk(rd, 32'h0);
    xfer(1'h0, ADDR_STATUS, 32'h0);
    chk(rd[0], 32'h1);
    xfer(1'h1, ADDR_SYSCFG, 32'h1);
    @(posedge hclk);
    go <= 1'h1;
    @(posedge hclk);
    go <= 1'h0;
    measure(1'h1);
    chk(boot_en, 32'h1);
    xfer(1'h0, ADDR_STATUS, 32'h0);
    chk(rd[0], 32'h1);
    @(posedge hclk);
    wdog <= 1'h1;
    @(posedge hclk);
    wdog <= 1'h0;
    measure(1'h0);
    xfer(1'h1, ADDR_CMD, 32'h2);
    repeat (2) @(posedge hclk);
    chk(rout_n, 32'h1);
    xfer(1'h1, ADDR_SYSCFG, 32'h1);
    xfer(1'h0, ADDR_SYSCFG, 32'h0);
    chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule : reset_pin_and_boot_mode_ctrl_bench

// ---- verification/rpbc_ext_reset.sv ----
// Open-drain external reset source on the shared reset input line
`timescale 1ns/1ps
module rpbc_ext_reset (
  input wire logic hclk,
  input wire logic go,
  input wire logic [7:0] len,
  input wire logic dut_o,
  input wire logic dut_oe,
  output logic line
);
  logic [7:0] cnt = 8'h00;
  always @(posedge hclk) begin
    if (go) begin
      cnt <= len;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
  // no emulation mode: reset output stays design-driven
  assign line = (dut_oe ? dut_o : 1'h1) & (cnt == 8'h00);
endmodule : rpbc_ext_reset
